// File: scfc_codec.sv
module scfc_codec
    import scfc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  command_code,
    output logic             command_strobe,
    output logic      [7:0]  top_address,
    output logic      [31:0] channel_select,
    output logic      [7:0]  sample_averaging,
    output logic      [7:0]  node_address,
    output logic      [7:0]  group_identifier,
    output logic             crc_error
);
    scfc_state_t state;
    scfc_state_t next_state;

    logic [7:0]  regs [0:255];
    logic [7:0]  dbuf [0:DBUF_DEPTH-1];
    logic        is_cmd;
    logic [2:0]  req;
    logic        asize;
    logic [7:0]  ident;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic [7:0]  dlen;
    logic [7:0]  idx;
    logic [6:0]  resp_len_m1;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic        fifo_in_ready;

    wire         take;
    wire         rx_is_cmd;
    wire [1:0]   rx_class;
    wire [1:0]   req_class;
    wire         reserved;
    wire         wants_resp;
    wire         id_match;
    wire         frame_ok;
    wire         act;
    wire         target_cmd;
    wire         last_data;
    wire         wr_to_top;
    wire         wr_en;
    wire [7:0]   wr_addr;
    wire [7:0]   rd_addr;
    wire [7:0]   rd_byte;
    wire         push_valid;
    wire [7:0]   push_data;
    wire         tx_push;
    wire         tx_feed;
    wire [7:0]   reply_m1;

    // Frame decode
    assign take       = rx_valid && rx_ready;
    assign rx_is_cmd  = rx_data[FRAME_KIND_BIT];
    assign rx_class   = rx_data[REQ_MSB:REQ_LSB+1];
    assign req_class  = req[2:1];
    assign reserved   = (req_class == CLASS_RESERVED);
    assign wants_resp = !req[RQ_NORESP_BIT];
    assign id_match   = (req_class == CLASS_BCAST) ||
                        ((req_class == CLASS_SINGLE) && (ident == node_address)) ||
                        ((req_class == CLASS_GROUP) && (ident == group_identifier));
    assign frame_ok   = (rx_crc == CRC_RESIDUE);
    assign act        = is_cmd && frame_ok && !reserved && id_match;
    assign target_cmd = (addr_hi == ADDR_HI_IMPLIED) && (addr_lo == REG_COMMAND_ENTRY);
    assign last_data  = (idx == dlen - LEN_ONE);
    assign reply_m1   = {1'b0, rx_data[REPLY_MSB:0]};

    // Register write path
    assign wr_to_top  = target_cmd && (idx == CMD_TOP_IDX);
    assign wr_addr    = (target_cmd && (idx != 8'h00)) ?
                        REG_COMMAND_ENTRY + idx - LEN_ONE : addr_lo + idx;
    assign wr_en      = (state == ST_WRITE) && (addr_hi == ADDR_HI_IMPLIED) && !wr_to_top &&
                        !(target_cmd && (idx > CMD_LAST_IDX));

    // Response path
    assign rd_addr    = addr_lo + idx;
    assign rd_byte    = (addr_hi == ADDR_HI_IMPLIED) ? regs[rd_addr] : REG_RESET;
    assign push_valid = (state == ST_RESP_HDR) || (state == ST_RESP_DATA) ||
                        (state == ST_RESP_CRC_A) || (state == ST_RESP_CRC_B);
    assign push_data  = (state == ST_RESP_HDR)   ? {1'b0, resp_len_m1} :
                        (state == ST_RESP_DATA)  ? rd_byte :
                        (state == ST_RESP_CRC_A) ? tx_crc[7:0] :
                        tx_crc[15:8];
    assign tx_push    = push_valid && fifo_in_ready;
    assign tx_feed    = tx_push && ((state == ST_RESP_HDR) || (state == ST_RESP_DATA));

    // Register outputs
    assign command_code     = regs[REG_COMMAND_ENTRY];
    assign channel_select   = {regs[REG_CHANNEL_SELECT], regs[REG_CHANNEL_SELECT + 8'h01],
                               regs[REG_CHANNEL_SELECT + 8'h02], regs[REG_CHANNEL_SELECT + 8'h03]};
    assign sample_averaging = regs[REG_SAMPLE_AVERAGING];
    assign node_address     = regs[REG_NODE_ADDRESS];
    assign group_identifier = regs[REG_GROUP_IDENTIFIER];

    // Checksum over received frame, cleared at the init byte
    scfc_crc16 u_rx_crc (
        .clk_sys (clk_sys),
        .srst    (srst),
        .start   (state == ST_INIT),
        .feed    (take),
        .data    (rx_data),
        .crc     (rx_crc)
    );

    // Checksum over reply, excluding its own checksum bytes
    scfc_crc16 u_tx_crc (
        .clk_sys (clk_sys),
        .srst    (srst),
        .start   (state == ST_RESP_HDR),
        .feed    (tx_feed),
        .data    (push_data),
        .crc     (tx_crc)
    );

    scfc_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // Frame sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_INIT:
                if (take)
                begin
                    if (!rx_is_cmd)
                        next_state = ST_DATA;
                    else if (rx_class == CLASS_BCAST)
                        next_state = rx_data[ADDR_SIZE_BIT] ? ST_RA_HI : ST_RA_LO;
                    else
                        next_state = ST_ID;
                end
            ST_ID:
                if (take)
                    next_state = asize ? ST_RA_HI : ST_RA_LO;
            ST_RA_HI:
                if (take)
                    next_state = ST_RA_LO;
            ST_RA_LO:
                if (take)
                    next_state = (dlen == 8'h00) ? ST_CRC_A : ST_DATA;
            ST_DATA:
                if (take && last_data)
                    next_state = ST_CRC_A;
            ST_CRC_A:
                if (take)
                    next_state = ST_CRC_B;
            ST_CRC_B:
                if (take)
                    next_state = ST_EVAL;
            ST_EVAL:
                if (!act)
                    next_state = ST_INIT;
                else if (!wants_resp || target_cmd)
                    next_state = (dlen == 8'h00) ? ST_INIT : ST_WRITE;
                else
                    next_state = ST_RESP_HDR;
            ST_WRITE:
                if (last_data)
                    next_state = ST_INIT;
            ST_RESP_HDR:
                if (tx_push)
                    next_state = ST_RESP_DATA;
            ST_RESP_DATA:
                if (tx_push && (idx == {1'b0, resp_len_m1}))
                    next_state = ST_RESP_CRC_A;
            ST_RESP_CRC_A:
                if (tx_push)
                    next_state = ST_RESP_CRC_B;
            ST_RESP_CRC_B:
                if (tx_push)
                    next_state = ST_INIT;
            default:
                next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state    <= ST_INIT;
            rx_ready <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            rx_ready <= (next_state <= ST_CRC_B);
        end
    end

    // Field capture
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            is_cmd      <= 1'b0;
            req         <= '0;
            asize       <= 1'b0;
            ident       <= REG_RESET;
            addr_hi     <= ADDR_HI_IMPLIED;
            addr_lo     <= REG_RESET;
            dlen        <= 8'h00;
            idx         <= 8'h00;
            resp_len_m1 <= '0;
        end
        else
        begin
            case (state)
                ST_INIT:
                    if (take)
                    begin
                        is_cmd  <= rx_is_cmd;
                        req     <= rx_data[REQ_MSB:REQ_LSB];
                        asize   <= rx_data[ADDR_SIZE_BIT];
                        addr_hi <= ADDR_HI_IMPLIED;
                        idx     <= 8'h00;
                        dlen    <= rx_is_cmd ? scfc_data_len(rx_data[DSIZE_MSB:DSIZE_LSB]) :
                                   reply_m1 + LEN_ONE;
                    end
                ST_ID:
                    if (take)
                        ident <= rx_data;
                ST_RA_HI:
                    if (take)
                        addr_hi <= rx_data;
                ST_RA_LO:
                    if (take)
                        addr_lo <= rx_data;
                ST_DATA:
                    if (take)
                        idx <= idx + LEN_ONE;
                ST_EVAL:
                begin
                    idx         <= 8'h00;
                    resp_len_m1 <= (dlen == 8'h00) ? 7'h00 :
                                   (dbuf[0] > {1'b0, REPLY_MAX_M1}) ? REPLY_MAX_M1 : dbuf[0][6:0];
                end
                ST_WRITE:
                    idx <= idx + LEN_ONE;
                ST_RESP_DATA:
                    if (tx_push)
                        idx <= idx + LEN_ONE;
                default:
                    idx <= idx;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if ((state == ST_DATA) && take && (idx < LEN_EIGHT))
            dbuf[idx[2:0]] <= rx_data;
    end

    // Register file and command side effects
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < 256; i++)
                regs[i] <= REG_RESET;
            top_address    <= REG_RESET;
            command_strobe <= 1'b0;
            crc_error      <= 1'b0;
        end
        else
        begin
            if (wr_en)
                regs[wr_addr] <= dbuf[idx[2:0]];
            if ((state == ST_WRITE) && wr_to_top)
                top_address <= dbuf[idx[2:0]];
            command_strobe <= (state == ST_WRITE) && last_data && target_cmd;
            crc_error      <= (state == ST_EVAL) && !frame_ok;
        end
    end

    // Checks
    sequence bad_eval_s;
        (state == ST_EVAL) && !frame_ok;
    endsequence

    sequence dropped_s;
        ##1 (crc_error && (state == ST_INIT));
    endsequence

    reply_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(state == ST_RESP_HDR) |-> $past(act && wants_resp && !target_cmd))
        else $error("reply started without a matching command");

    reply_header_a: assert property (@(posedge clk_sys) disable iff (srst)
        (tx_push && (state == ST_RESP_HDR)) |->
            (!push_data[FRAME_KIND_BIT] && (push_data[REPLY_MSB:0] == resp_len_m1)))
        else $error("reply header kind or length wrong");

    upper_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        ((state == ST_RA_LO) && !asize) |-> (addr_hi == ADDR_HI_IMPLIED))
        else $error("implied upper address byte not zero");

    eight_bytes_a: assert property (@(posedge clk_sys) disable iff (srst)
        ((state == ST_INIT) && take && rx_is_cmd && (rx_data[DSIZE_MSB:DSIZE_LSB] == DSIZE_EIGHT))
            |=> (dlen == LEN_EIGHT))
        else $error("size code seven not taken as eight bytes");

    id_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(state == ST_WRITE) |-> $past(id_match && frame_ok && !reserved))
        else $error("register write without identifier match");

    command_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        command_strobe |-> (command_code == dbuf[0]))
        else $error("command strobe without command byte stored");

    crc_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
        bad_eval_s |-> dropped_s)
        else $error("bad checksum frame not dropped");

    reserved_skip_a: assert property (@(posedge clk_sys) disable iff (srst)
        ((state == ST_EVAL) && reserved) |=> ((state == ST_INIT) && !wr_en)
            ##1 ((state != ST_WRITE) && (state != ST_RESP_HDR)))
        else $error("reserved request acted upon");

    crc_tail_a: assert property (@(posedge clk_sys) disable iff (srst)
        (tx_push && (state == ST_RESP_CRC_A)) |-> (push_data == tx_crc[7:0])
            ##1 ((state == ST_RESP_CRC_B) && (push_data == tx_crc[15:8]))[*1])
        else $error("reply checksum bytes out of order");
endmodule

// File: scfc_pkg.sv
// Contract
// - Device sends a response only after receiving a command frame from the host.
// - Every frame starts with an init byte that alone gives the frame length.
// - Init bit 7 is one for command frames, zero for response frames.
// - Request type selects single, group or broadcast, with or without response.
// - Address-size bit selects one or two register address bytes.
// - With one address byte the upper address byte is taken as zero.
// - Data-size codes 0 to 6 mean that many bytes, code 7 eight.
// - Response init low bits carry the reply data byte count minus one.
// - Single or group requests act only on node or group identifier match.
// - Request type picks node address or group identifier for the comparison.
// - Broadcast frames carry no identifier byte; address follows init directly.
// - Command register writes carry command, top address, channel select, averaging.
// - Write without response stores data bytes into the addressed registers.
// - Write with response returns addressed register contents in the reply; at the command register the code stores instead, no reply.
// - Frames end in two checksum bytes, low generated byte first.
// - Checksum uses polynomial x16 + x15 + x2 + 1 in serial bit order.
// - Checksum register starts at all zeros before the first frame bit.
// - Bytes go least significant bit first; checksum follows that order.
// - Checksum over whole frame with its checksum bytes leaves zero when good.
package scfc_pkg;

    localparam int unsigned BYTE_W          = 8;
    localparam int unsigned TX_FIFO_DEPTH   = 32;
    localparam int unsigned DBUF_DEPTH      = 8;

    localparam int unsigned FRAME_KIND_BIT  = 7;
    localparam int unsigned REQ_MSB         = 6;
    localparam int unsigned REQ_LSB         = 4;
    localparam int unsigned ADDR_SIZE_BIT   = 3;
    localparam int unsigned DSIZE_MSB       = 2;
    localparam int unsigned DSIZE_LSB       = 0;
    localparam int unsigned REPLY_MSB       = 6;
    localparam int unsigned RQ_NORESP_BIT   = 0;

    localparam logic [1:0]  CLASS_SINGLE    = 2'h0;
    localparam logic [1:0]  CLASS_GROUP     = 2'h1;
    localparam logic [1:0]  CLASS_RESERVED  = 2'h2;
    localparam logic [1:0]  CLASS_BCAST     = 2'h3;

    localparam logic [2:0]  DSIZE_EIGHT     = 3'h7;
    localparam logic [7:0]  LEN_EIGHT       = 8'h08;
    localparam logic [7:0]  LEN_ONE         = 8'h01;
    localparam logic [6:0]  REPLY_MAX_M1    = 7'h7f;

    localparam logic [7:0]  REG_COMMAND_ENTRY    = 8'h02;
    localparam logic [7:0]  REG_CHANNEL_SELECT   = 8'h03;
    localparam logic [7:0]  REG_SAMPLE_AVERAGING = 8'h07;
    localparam logic [7:0]  REG_NODE_ADDRESS     = 8'h0a;
    localparam logic [7:0]  REG_GROUP_IDENTIFIER = 8'h0b;
    localparam logic [7:0]  REG_RESET            = 8'h00;
    localparam logic [7:0]  ADDR_HI_IMPLIED      = 8'h00;
    localparam logic [7:0]  CMD_TOP_IDX          = 8'h01;
    localparam logic [7:0]  CMD_LAST_IDX         = 8'h06;

    localparam logic [15:0] CRC_INIT        = 16'h0000;
    localparam logic [15:0] CRC_POLY        = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

    typedef enum logic [3:0] {
        ST_INIT, ST_ID, ST_RA_HI, ST_RA_LO, ST_DATA, ST_CRC_A, ST_CRC_B, ST_EVAL,
        ST_WRITE, ST_RESP_HDR, ST_RESP_DATA, ST_RESP_CRC_A, ST_RESP_CRC_B
    } scfc_state_t;

    function automatic logic [7:0] scfc_data_len(input logic [2:0] size_code);
        scfc_data_len = (size_code == DSIZE_EIGHT) ? LEN_EIGHT : {5'h00, size_code};
    endfunction

endpackage

// File: scfc_crc16.sv
module scfc_crc16
    import scfc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic        feed,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    logic [15:0] seed;
    logic [15:0] next_crc;

    assign seed = start ? CRC_INIT : crc;

    // Reflected serial form, bit 0 first
    always_comb
    begin
        next_crc = seed;
        for (int i = 0; i < BYTE_W; i++)
        begin
            if (next_crc[0] ^ data[i])
                next_crc = (next_crc >> 1) ^ CRC_POLY;
            else
                next_crc = next_crc >> 1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            crc <= CRC_INIT;
        else if (feed)
            crc <= next_crc;
    end
endmodule

// File: scfc_fifo.sv
module scfc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
)
(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR   = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push;
    wire              load;

    assign in_ready = (count != FULL_COUNT);
    assign push     = in_valid && in_ready;
    assign load     = (count != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // Output stage keeps the read side registered
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            if (load)
            begin
                rd_ptr    <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
            count <= count + (AW+1)'(push) - (AW+1)'(load);
        end
    end
endmodule

// File: scfc_host.sv
module scfc_host
(
    input  wire logic       clk_sys,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [$];
    logic       stall = 1'b0;
    assign tx_ready = !stall;
    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    // Collects reply bytes
    always @(posedge clk_sys)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    function automatic logic [15:0] crc16(input logic [7:0] f [$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (f[i])
        begin
            c = c ^ {8'h00, f[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    // Sends one command frame, check appended; bad flips one check bit
    task automatic send(input logic [7:0] f [$], input logic bad);
        logic [15:0] c;
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8] ^ {7'h00, bad});
        foreach (f[i])
        begin
            rx_data <= f[i];
            rx_valid <= 1'b1;
            @(posedge clk_sys);
            while (rx_ready !== 1'b1) @(posedge clk_sys);
        end
        rx_valid <= 1'b0;
        rx_data <= ~f[f.size()-1];
    endtask
endmodule

// File: tb_top.sv
module tb_top;
    import scfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [79:0] f;
        logic [3:0]  n;
        logic [71:0] e;
    } scfc_row_t;
    logic        clk_sys;
    logic        srst;
    logic [7:0]  rx_data, tx_data, command_code, top_address;
    logic [7:0]  sample_averaging, node_address, group_identifier;
    logic [31:0] channel_select;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, command_strobe, crc_error;
    int          fails = 0, n_compared = 0, cycles = 0, n_strobe = 0, n_err = 0;
    logic [7:0]  crc_ex [$] = '{8'h91, 8'h03, 8'h07, 8'h05};
    wire  [71:0] regs = {command_code, top_address, channel_select,
                         sample_averaging, node_address, group_identifier};
    localparam scfc_row_t ROWS [10] = '{
        '{80'hf1_0a03, 4'h3, 72'h00_0000_0000_0000_0300},
        '{80'hf1_0b05, 4'h3, 72'h00_0000_0000_0000_0305},
        '{80'h9103_0705, 4'h4, 72'h00_0000_0000_0005_0305},
        '{80'h9104_0709, 4'h4, 72'h00_0000_0000_0005_0305},
        '{80'hb105_070c, 4'h4, 72'h00_0000_0000_000c_0305},
        '{80'hb103_070d, 4'h4, 72'h00_0000_0000_000c_0305},
        '{80'hc103_070e, 4'h4, 72'h00_0000_0000_000c_0305},
        '{80'h99_0300_0711, 4'h5, 72'h00_0000_0000_0011_0305},
        '{80'h99_0301_0712, 4'h5, 72'h00_0000_0000_0011_0305},
        '{80'hf702_aa0f_0102_0304_2100, 4'ha, 72'haa_0f01_0203_0421_0305}
    };
    scfc_codec i_scfc_codec (.clk_sys(clk_sys), .srst(srst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .command_code(command_code), .command_strobe(command_strobe),
        .top_address(top_address), .channel_select(channel_select),
        .sample_averaging(sample_averaging), .node_address(node_address),
        .group_identifier(group_identifier), .crc_error(crc_error));
    scfc_host i_scfc_host (.clk_sys(clk_sys), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic results();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [71:0] a, input logic [71:0] b, input string m);
        n_compared++;
        if (a !== b)
        begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Pulse counters and hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (command_strobe === 1'b1)
            n_strobe++;
        if (crc_error === 1'b1)
            n_err++;
        if (cycles == 5000)
        begin
            fails++;
            results();
        end
    end
    task automatic run(input logic [79:0] f, input logic [3:0] n, input logic bad);
        logic [7:0] q [$];
        int         k;
        @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) q.push_back(f[i*8 +: 8]);
        i_scfc_host.send(q, bad);
        repeat (2) @(posedge clk_sys);
        k = 0;
        while (rx_ready !== 1'b1 && k < 300)
        begin
            @(posedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
    endtask
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (i_scfc_host.got.size() < n && k < 500)
        begin
            @(posedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        check(72'(i_scfc_host.got.size()), 72'(n), "reply count");
        check(72'(i_scfc_host.crc16(i_scfc_host.got)), 72'h0, "reply crc");
    endtask
    initial
    begin
        srst = 1'b1;
        repeat (8) @(posedge clk_sys);
        check(regs, 72'h0, "reset regs");
        check(72'({rx_ready, tx_valid, command_strobe, crc_error}), 72'h0, "reset ready");
        check(72'(i_scfc_host.crc16(crc_ex)), 72'hcf1e, "crc example");
        srst <= 1'b0;
        foreach (ROWS[i])
        begin
            run(ROWS[i].f, ROWS[i].n, 1'b0);
            check(regs, ROWS[i].e, "row regs");
            check(72'(i_scfc_host.got.size()), 72'h0, "reply to write");
        end
        check(72'(n_strobe), 72'h1, "strobe count");
        check(72'(n_err), 72'h0, "false check error");
        run(80'h9103_0777, 4'h4, 1'b1);
        check(regs, ROWS[9].e, "bad frame stored");
        check(72'(n_err), 72'h1, "check error pulse");
        run(80'h80_0307, 4'h3, 1'b0);
        wait_got(4);
        check(72'({i_scfc_host.got[0], i_scfc_host.got[1]}), 72'h0021, "read");
        i_scfc_host.got.delete();
        run(80'he1_0a01, 4'h3, 1'b0);
        wait_got(5);
        check(72'({i_scfc_host.got[0], i_scfc_host.got[1], i_scfc_host.got[2]}),
              72'h01_0305, "broadcast read");
        i_scfc_host.got.delete();
        i_scfc_host.stall <= 1'b1;
        run(80'he1_0a27, 4'h3, 1'b0);
        check(72'(rx_ready), 72'h0, "input held during reply");
        i_scfc_host.stall <= 1'b0;
        wait_got(43);
        check(72'(i_scfc_host.got[0]), 72'h27, "long header");
        i_scfc_host.got.delete();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(regs, 72'h0, "mid reset regs");
        srst <= 1'b0;
        run(ROWS[0].f, ROWS[0].n, 1'b0);
        check(regs, ROWS[0].e, "after reset");
        results();
    end
endmodule
